//--- design/rsc_top.sv
// Reset source controller: merges every reset source except the idle watchdog timeout into one system reset.
// Assumes synchronous pin and monitor inputs and an Avalon-MM master on the bus.
//
// How it works
// [R1] Any reset clears the program counter.
// [R2] Power-on loads port data and direction ones.
// [R3] Low clear pin resets; resumes when high.
// [R4] Extra start delay after clear pin release.
// [R5] Board holds clear pin low until stable.
// [R6] Supply trip on while running, off idle.
// [R7] Supply low trip resets and sets flag.
// [R8] Short low-supply glitches under filter ignored.
// [R9] Four threshold codes map to trip levels.
// [R10] Genuine supply trip keeps threshold select.
// [R11] Undefined code resets after delay, restores.
// [R12] Undefined code sets threshold fault flag.
// [R13] Threshold select powers up at 0x55.
// [R14] Bit 2 supply flag; software zero clears.
// [R15] Bit 1 fault flag; only software clears (power-on srst also clears it).
// [R16] Cause bits 7 to 3 read zero.
// [R17] Writing 0x55 to selfprog register resets.
// [R18] Running watchdog timeout: full reset, flag set.
// [R19] Idle timeout clears only counter and stack.
// [R20] Expired and halt flags follow reset kind.
// [R21] Bad watchdog enable code resets, sets fault.
// [R22] Reset asserts at once, releases synchronously.
module rsc_top (
   // Clock and power-on reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Reset sources and mode
   input  wire logic        external_clear_pin_n,
   input  wire logic        supply_below_level,
   input  wire logic        wdog_timeout,
   input  wire logic        idle_mode,
   input  wire logic        halt_exec,
   input  wire logic        wdog_clear,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Reset outputs to the core
   output logic             sys_reset,
   output logic             pc_sp_clear,
   output logic             port_preset,
   output logic             low_supply_trip_en,
   output logic      [1:0]  trip_level_field,
   output logic             watchdog_expired_flag,
   output logic             halt_flag,
   output logic             wdog_enabled
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      rsc_pkg::rsc_state_t     st;
      logic [rsc_pkg::CNT_W-1:0] cnt;
      logic [rsc_pkg::CNT_W-1:0] filt;
      logic [7:0]              trip_sel;
      logic [7:0]              wdog_ctrl;
      logic                    supply_flag;
      logic                    thr_fault;
      logic                    wd_fault;
      logic                    expired;
      logic                    halted;
      logic                    pcsp;
      logic                    por;
      logic                    ack;
      logic [31:0]             rdata;
   } rsc_regs_t;

   rsc_regs_t s_reg;
   rsc_regs_t s_next;

   // Decodes a threshold code; returns 1 when it is one of the four levels.
   function automatic logic code_valid(input logic [7:0] c);
      code_valid = (c == rsc_pkg::LVL_2V10) || (c == rsc_pkg::LVL_2V55) ||
                   (c == rsc_pkg::LVL_3V15) || (c == rsc_pkg::LVL_3V80); // [R9]
   endfunction : code_valid

   // Maps a threshold code onto the comparator level select.
   function automatic logic [1:0] code_level(input logic [7:0] c);
      case (c)
         rsc_pkg::LVL_2V55: code_level = rsc_pkg::LV_2V55;
         rsc_pkg::LVL_3V15: code_level = rsc_pkg::LV_3V15;
         rsc_pkg::LVL_3V80: code_level = rsc_pkg::LV_3V80;
         default:           code_level = rsc_pkg::LV_2V10;
      endcase
   endfunction : code_level

   function automatic logic wd_code_valid(input logic [4:0] c);
      wd_code_valid = (c == rsc_pkg::WDOG_EN_CODE) || (c == rsc_pkg::WDOG_DIS_CODE);
   endfunction : wd_code_valid

   logic wr_hit;
   logic rd_hit;
   logic trip_fire;
   logic run;
   logic bad_thr;
   logic bad_wd;
   logic sp_hit;

   // Bus strobes; one wait cycle then acknowledge.
   assign wr_hit  = avs_write && !s_reg.ack;
   assign rd_hit  = avs_read && !s_reg.ack;
   assign run     = (s_reg.st == rsc_pkg::ST_RUN);
   assign bad_thr = !code_valid(s_reg.trip_sel);
   assign bad_wd  = !wd_code_valid(s_reg.wdog_ctrl[7:3]);
   assign sp_hit  = wr_hit && avs_byteenable[0] && avs_address == rsc_pkg::OFS_SELFPROG &&
                    avs_writedata[7:0] == rsc_pkg::SELFPROG_RESET;
   // Filter done: low supply persisted longer than the filter window.
   assign trip_fire = low_supply_trip_en && supply_below_level &&
                      (s_reg.filt >= rsc_pkg::CNT_W'(rsc_pkg::LOW_FILTER_CYC)); // [R8]

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      s_next      = s_reg;
      s_next.ack  = (avs_read || avs_write) && !s_reg.ack;
      s_next.pcsp = 1'b0;
      s_next.por  = 1'b0;
      // Glitch filter counts only while the supply is low and monitor enabled.
      if (low_supply_trip_en && supply_below_level) begin
         if (!trip_fire) begin
            s_next.filt = s_reg.filt + 1'b1; // [R8]
         end
      end else begin
         s_next.filt = '0;
      end
      // Register writes; hardware sets below take priority over clears.
      if (wr_hit && avs_byteenable[0]) begin
         case (avs_address)
            rsc_pkg::OFS_TRIP_SELECT: s_next.trip_sel  = avs_writedata[7:0];
            rsc_pkg::OFS_WDOG_CTRL:   s_next.wdog_ctrl = avs_writedata[7:0];
            rsc_pkg::OFS_CAUSE_FLAGS: begin
               if (!avs_writedata[rsc_pkg::BIT_SUPPLY_TRIP]) begin
                  s_next.supply_flag = 1'b0; // [R14]
               end
               if (!avs_writedata[rsc_pkg::BIT_THRESH_FAULT]) begin
                  s_next.thr_fault = 1'b0; // [R15]
               end
               if (!avs_writedata[rsc_pkg::BIT_WDOG_FAULT]) begin
                  s_next.wd_fault = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Halt and watchdog clear drive the halt flag in the core.
      if (halt_exec) begin
         s_next.halted = 1'b1;
      end else if (wdog_clear) begin
         s_next.halted = 1'b0;
      end
      // Flag sets always win over a same-cycle clear.
      if (bad_thr) begin
         s_next.thr_fault = 1'b1; // [R12] [R15]
      end
      if (bad_wd) begin
         s_next.wd_fault = 1'b1; // [R21]
      end
      // Reset sequencer.
      case (s_reg.st)
         rsc_pkg::ST_RUN: begin
            if (!external_clear_pin_n) begin
               s_next.st = rsc_pkg::ST_HOLD; // [R3] [R5]
            end else if (trip_fire) begin
               s_next.st          = rsc_pkg::ST_RELEASE; // [R7] [R10]
               s_next.supply_flag = 1'b1; // [R14]
               s_next.cnt         = rsc_pkg::CNT_W'(rsc_pkg::PIN_RELEASE_CYC);
            end else if (wdog_timeout && idle_mode) begin
               s_next.pcsp    = 1'b1; // [R19]
               s_next.expired = 1'b1; // [R20]
               s_next.halted  = 1'b1; // [R20]
            end else if (wdog_timeout) begin
               s_next.st      = rsc_pkg::ST_RELEASE; // [R18]
               s_next.expired = 1'b1; // [R20]
               s_next.cnt     = rsc_pkg::CNT_W'(rsc_pkg::PIN_RELEASE_CYC);
            end else if (bad_thr || bad_wd || sp_hit) begin
               s_next.st  = rsc_pkg::ST_SOFTWAIT; // [R11] [R17] [R21]
               s_next.cnt = rsc_pkg::CNT_W'(rsc_pkg::SOFT_TRIGGER_CYC);
            end
         end
         rsc_pkg::ST_SOFTWAIT: begin
            if (s_reg.cnt <= rsc_pkg::CNT_W'(1)) begin
               s_next.st  = rsc_pkg::ST_RELEASE;
               s_next.cnt = rsc_pkg::CNT_W'(rsc_pkg::PIN_RELEASE_CYC);
               if (bad_thr) begin
                  s_next.trip_sel = rsc_pkg::TRIP_SEL_RESET; // [R11]
               end
               if (bad_wd) begin
                  s_next.wdog_ctrl = rsc_pkg::WDOG_CTRL_RESET;
               end
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         rsc_pkg::ST_HOLD: begin
            s_next.cnt = rsc_pkg::CNT_W'(rsc_pkg::PIN_RELEASE_CYC);
            if (external_clear_pin_n) begin
               s_next.st = rsc_pkg::ST_RELEASE; // [R4]
            end
         end
         rsc_pkg::ST_RELEASE: begin
            if (!external_clear_pin_n) begin
               s_next.st = rsc_pkg::ST_HOLD; // [R3]
            end else if (s_reg.cnt <= rsc_pkg::CNT_W'(1)) begin
               s_next.st = rsc_pkg::ST_RUN; // [R4] [R22]
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         default: s_next.st = rsc_pkg::ST_HOLD;
      endcase
      // Read data for the access being acknowledged next cycle.
      s_next.rdata = '0;
      if (rd_hit) begin
         case (avs_address)
            rsc_pkg::OFS_TRIP_SELECT: s_next.rdata = {24'h000000, s_reg.trip_sel};
            rsc_pkg::OFS_CAUSE_FLAGS: s_next.rdata = {29'h00000000, s_reg.supply_flag,
                                                      s_reg.thr_fault, s_reg.wd_fault}; // [R16]
            rsc_pkg::OFS_WDOG_CTRL:   s_next.rdata = {24'h000000, s_reg.wdog_ctrl};
            default:                  s_next.rdata = 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // State register; power-on reset is srst
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg             <= '0;
         s_reg.st          <= rsc_pkg::ST_RELEASE;
         s_reg.cnt         <= rsc_pkg::CNT_W'(rsc_pkg::PIN_RELEASE_CYC);
         s_reg.trip_sel    <= rsc_pkg::TRIP_SEL_RESET; // [R13]
         s_reg.wdog_ctrl   <= rsc_pkg::WDOG_CTRL_RESET;
         s_reg.por         <= 1'b1; // [R2]
      end else begin
         s_reg <= s_next;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Reset asserts combinationally from a low pin, releases on the clock.
   // A soft reset request only takes effect once its delay has run out.
   assign sys_reset = srst || !external_clear_pin_n ||
                      !(run || s_reg.st == rsc_pkg::ST_SOFTWAIT); // [R1] [R11] [R22]
   assign pc_sp_clear = s_reg.pcsp || sys_reset; // [R1] [R19]
   assign port_preset = s_reg.por || srst; // [R2]
   assign low_supply_trip_en = run && !idle_mode; // [R6]
   assign trip_level_field = code_level(s_reg.trip_sel); // [R9]
   assign watchdog_expired_flag = s_reg.expired;
   assign halt_flag = s_reg.halted;
   assign wdog_enabled = (s_reg.wdog_ctrl[7:3] == rsc_pkg::WDOG_EN_CODE);
   assign avs_readdata = s_reg.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   sequence low_held_s;
      supply_below_level && low_supply_trip_en;
   endsequence

   pin_reset_a: assert property (@(posedge clk) disable iff (srst) // [R3]
      !external_clear_pin_n |-> sys_reset)
      else $error("Clear pin low without system reset.");
   pin_delay_a: assert property (@(posedge clk) disable iff (srst) // [R4]
      (s_reg.st == rsc_pkg::ST_HOLD) && external_clear_pin_n |=> !run [*8])
      else $error("Run resumed without start delay.");
   trip_idle_a: assert property (@(posedge clk) disable iff (srst) // [R6]
      idle_mode |-> !low_supply_trip_en)
      else $error("Supply trip enabled in idle.");
   glitch_ign_a: assert property (@(posedge clk) disable iff (srst) // [R8]
      low_held_s ##0 (s_reg.filt < rsc_pkg::CNT_W'(rsc_pkg::LOW_FILTER_CYC)) &&
      external_clear_pin_n && !wdog_timeout && !bad_thr && !bad_wd && !sp_hit |=> run)
      else $error("Short supply glitch caused reset.");
   trip_flag_a: assert property (@(posedge clk) disable iff (srst) // [R7]
      run && external_clear_pin_n && trip_fire |=> s_reg.supply_flag && !run)
      else $error("Supply trip did not set flag and reset.");
   keep_sel_a: assert property (@(posedge clk) disable iff (srst) // [R10]
      run && external_clear_pin_n && trip_fire && !wr_hit |=> $stable(s_reg.trip_sel))
      else $error("Threshold select changed on supply trip.");
   thr_fault_a: assert property (@(posedge clk) disable iff (srst) // [R12]
      bad_thr |=> s_reg.thr_fault)
      else $error("Undefined code did not set fault flag.");
   sp_reset_a: assert property (@(posedge clk) disable iff (srst) // [R17]
      run && external_clear_pin_n && !trip_fire && !wdog_timeout && sp_hit
      |=> s_reg.st == rsc_pkg::ST_SOFTWAIT)
      else $error("Selfprog write did not start reset.");
   cause_zero_a: assert property (@(posedge clk) disable iff (srst) // [R16]
      !avs_waitrequest && avs_read && avs_address == rsc_pkg::OFS_CAUSE_FLAGS
      |-> avs_readdata[31:3] == 29'h00000000)
      else $error("Unimplemented cause bits read nonzero.");
   idle_wd_a: assert property (@(posedge clk) disable iff (srst) // [R19]
      run && external_clear_pin_n && !trip_fire && wdog_timeout && idle_mode
      |=> pc_sp_clear && run && watchdog_expired_flag && halt_flag)
      else $error("Idle watchdog timeout mishandled.");
   soft_delay_a: assert property (@(posedge clk) disable iff (srst) // [R11]
      (s_reg.st == rsc_pkg::ST_SOFTWAIT) && external_clear_pin_n |-> !sys_reset)
      else $error("Soft reset asserted before its delay.");
   wdog_run_a: assert property (@(posedge clk) disable iff (srst) // [R18]
      run && external_clear_pin_n && !trip_fire && wdog_timeout && !idle_mode
      |=> sys_reset && watchdog_expired_flag)
      else $error("Running watchdog timeout did not reset.");
   por_ports_a: assert property (@(posedge clk) disable iff (srst) // [R2]
      $fell(srst) |-> port_preset)
      else $error("Ports not preset after power-on.");

endmodule : rsc_top

//--- inc/rsc_pkg.sv
// Package for the reset source controller: offsets, fields, reset values, timing.
// Assumes a 50 MHz system clock and an Avalon-MM register slave with 32-bit data.
package rsc_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ            = 50_000_000;
   localparam int CLK_PERIOD_NS     = 20;
   localparam int PIN_RELEASE_US    = 100;
   localparam int PIN_RELEASE_CYC   = (PIN_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_TRIGGER_US   = 50;
   localparam int SOFT_TRIGGER_CYC  = (SOFT_TRIGGER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_FILTER_US     = 120;
   localparam int LOW_FILTER_CYC    = (LOW_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W             = 16;

   // ------------------------------------------------------------------
   // Register map, byte addresses
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_TRIP_SELECT = 4'h0;
   localparam logic [3:0] OFS_CAUSE_FLAGS = 4'h4;
   localparam logic [3:0] OFS_SELFPROG    = 4'h8;
   localparam logic [3:0] OFS_WDOG_CTRL   = 4'hC;

   // ------------------------------------------------------------------
   // Fields and codes
   // ------------------------------------------------------------------
   localparam int         BIT_WDOG_FAULT   = 0;
   localparam int         BIT_THRESH_FAULT = 1;
   localparam int         BIT_SUPPLY_TRIP  = 2;
   localparam logic [7:0] TRIP_SEL_RESET   = 8'h55;
   localparam logic [7:0] LVL_2V10         = 8'h55;
   localparam logic [7:0] LVL_2V55         = 8'h33;
   localparam logic [7:0] LVL_3V15         = 8'h99;
   localparam logic [7:0] LVL_3V80         = 8'hAA;
   localparam logic [7:0] SELFPROG_RESET   = 8'h55;
   localparam logic [4:0] WDOG_EN_CODE     = 5'h0A;
   localparam logic [4:0] WDOG_DIS_CODE    = 5'h15;
   localparam logic [7:0] WDOG_CTRL_RESET  = 8'h53;

   // ------------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RUN      = 4'b0001,
      ST_HOLD     = 4'b0010,
      ST_RELEASE  = 4'b0100,
      ST_SOFTWAIT = 4'b1000
   } rsc_state_t;

   typedef enum logic [1:0] {
      LV_2V10 = 2'h0,
      LV_2V55 = 2'h1,
      LV_3V15 = 2'h2,
      LV_3V80 = 2'h3
   } rsc_level_t;

endpackage : rsc_pkg

//--- sim/rsc_rc_network.sv
// Behavioural model of the board RC reset network and the supply monitor.
// Assumes the bench requests button presses and supply dips as levels on clk.
module rsc_rc_network #(
   parameter int RC_CYC = 20
) (
   // Clock and power-on reset
   input  wire logic clk,
   input  wire logic srst,
   // Requests from the bench
   input  wire logic clear_req,
   input  wire logic dip_req,
   // Lines into the block
   output logic      external_clear_pin_n,
   output logic      supply_below_level
);
   timeunit 1ns;
   timeprecision 1ps;

   int rc_cnt;

   // The capacitor charges for a while after power-up before the pin rises.
   always @(posedge clk) begin
      if (srst) begin
         rc_cnt <= RC_CYC;
      end else if (rc_cnt > 0) begin
         rc_cnt <= rc_cnt - 1;
      end
   end

   // The pin stays low while charging or while the button is pressed.
   assign external_clear_pin_n = !(srst || rc_cnt > 0 || clear_req);
   // The comparator output follows the simulated supply dip.
   assign supply_below_level   = dip_req;
endmodule : rsc_rc_network

//--- sim/reset_source_controller_test.sv
// Self-checking bench for the reset source controller.
// Assumes a 50 MHz clock and the board network model on the pin and monitor.
module reset_source_controller_test;
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------------
   // Signals and counters
   // -------------------------------------------------------------------
   localparam int SOFT = rsc_pkg::SOFT_TRIGGER_CYC;
   localparam int PINC = rsc_pkg::PIN_RELEASE_CYC;
   localparam int FILT = rsc_pkg::LOW_FILTER_CYC;
   logic clk = 1'b0, srst = 1'b1, clear_req = 1'b0, dip_req = 1'b0;
   logic wdog_timeout = 1'b0, idle_mode = 1'b0, halt_exec = 1'b0, wdog_clear = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pin_n, below;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic sys_reset, pc_sp_clear, port_preset, low_supply_trip_en;
   logic watchdog_expired_flag, halt_flag, wdog_enabled;
   logic [1:0] trip_level_field;
   int n_errors = 0, samples_checked = 0, cycles = 0, n;

   // Clock generator.
   always #10 clk = ~clk;

   rsc_rc_network u_rsc_rc_network (.clk(clk), .srst(srst), .clear_req(clear_req),
      .dip_req(dip_req), .external_clear_pin_n(pin_n), .supply_below_level(below));

   rsc_top u_rsc_top (.clk(clk), .srst(srst), .external_clear_pin_n(pin_n),
      .supply_below_level(below), .wdog_timeout(wdog_timeout), .idle_mode(idle_mode),
      .halt_exec(halt_exec), .wdog_clear(wdog_clear), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
      .port_preset(port_preset), .low_supply_trip_en(low_supply_trip_en),
      .trip_level_field(trip_level_field), .watchdog_expired_flag(watchdog_expired_flag),
      .halt_flag(halt_flag), .wdog_enabled(wdog_enabled));

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   // Prints the verdict and ends the run.
   task automatic finish_test;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // Compares one value and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One Avalon access; the request is held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus

   // Reads a register and compares it.
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd_chk

   // Counts cycles until the system reset shows the wanted level.
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      @(negedge clk);
      while (sys_reset !== lvl && n < lim) begin
         n++;
         @(negedge clk);
      end
      if (n == lim) n_errors++;
      @(posedge clk);
   endtask : wait_rst

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   // Power-on reset, then the reset values seen by software.
   task automatic t_por;
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check(port_preset, 1'b1);
      check(pc_sp_clear, 1'b1);
      @(posedge clk);
      srst <= 1'b0;
      wait_rst(1'b0, PINC + 100);
      check(n >= PINC - 2 && n <= PINC + 30, 1'b1);
      check({watchdog_expired_flag, halt_flag, low_supply_trip_en}, 3'h1);
      rd_chk(rsc_pkg::OFS_TRIP_SELECT, 32'h55);
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
      check(trip_level_field, 2'h0);
   endtask : t_por

   // Each defined level code maps to its trip level.
   task automatic t_levels;
      logic [7:0] codes [4] = '{rsc_pkg::LVL_2V10, rsc_pkg::LVL_2V55,
                                rsc_pkg::LVL_3V15, rsc_pkg::LVL_3V80};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, rsc_pkg::OFS_TRIP_SELECT, {24'h0, codes[i]});
         check(trip_level_field, i[1:0]);
      end
   endtask : t_levels

   // Idle watchdog time-out clears only counter and stack; monitor is off.
   task automatic t_idle;
      halt_exec <= 1'b1;
      idle_mode <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      dip_req   <= 1'b1;
      @(negedge clk);
      check(low_supply_trip_en, 1'b0);
      repeat (FILT + 50) @(posedge clk);
      dip_req      <= 1'b0;
      wdog_timeout <= 1'b1;
      @(posedge clk);
      wdog_timeout <= 1'b0;
      @(negedge clk);
      check({pc_sp_clear, sys_reset}, 2'h2);
      @(negedge clk);
      check({pc_sp_clear, watchdog_expired_flag, halt_flag}, 3'h3);
      @(posedge clk);
      idle_mode <= 1'b0;
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
   endtask : t_idle

   // Running watchdog time-out gives a full reset and leaves halt alone.
   task automatic t_wdog_run;
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec    <= 1'b0;
      wdog_timeout <= 1'b1;
      @(posedge clk);
      wdog_timeout <= 1'b0;
      wait_rst(1'b1, 5);
      check(n < 5, 1'b1);
      wait_rst(1'b0, PINC + 100);
      check({watchdog_expired_flag, halt_flag}, 2'h3);
   endtask : t_wdog_run

   // Clear pin resets at once and releases after the start delay.
   task automatic t_pin;
      clear_req <= 1'b1;
      @(negedge clk);
      check({sys_reset, pc_sp_clear}, 2'h3);
      repeat (10) @(posedge clk);
      clear_req <= 1'b0;
      wait_rst(1'b0, PINC + 100);
      check(n >= PINC - 2 && n <= PINC + 3, 1'b1);
      check({watchdog_expired_flag, halt_flag}, 2'h3);
      wdog_clear <= 1'b1;
      @(posedge clk);
      wdog_clear <= 1'b0;
      @(posedge clk);
      check(halt_flag, 1'b0);
   endtask : t_pin

   // Short dip ignored; long dip trips, keeps the level, sets a sticky flag.
   task automatic t_supply;
      bus(1'b1, rsc_pkg::OFS_TRIP_SELECT, 32'h99);
      dip_req <= 1'b1;
      repeat (FILT - 200) @(posedge clk);
      dip_req <= 1'b0;
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
      dip_req <= 1'b1;
      wait_rst(1'b1, FILT + 20);
      dip_req <= 1'b0;
      check(n >= FILT - 5 && n <= FILT + 5, 1'b1);
      wait_rst(1'b0, PINC + 100);
      rd_chk(rsc_pkg::OFS_TRIP_SELECT, 32'h99);
      bus(1'b1, rsc_pkg::OFS_CAUSE_FLAGS, 32'h4);
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h4);
      bus(1'b1, rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
   endtask : t_supply

   // A write that starts a delayed soft reset, then the cause flags.
   task automatic t_soft(input logic [3:0] a, input logic [31:0] d,
                         input logic [31:0] cause);
      bus(1'b1, a, d);
      wait_rst(1'b1, SOFT + 20);
      check(n >= SOFT - 5 && n <= SOFT + 3, 1'b1);
      wait_rst(1'b0, PINC + 100);
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, cause);
      rd_chk(rsc_pkg::OFS_TRIP_SELECT, 32'h55);
      bus(1'b1, rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
      rd_chk(rsc_pkg::OFS_CAUSE_FLAGS, 32'h0);
   endtask : t_soft

   // Watchdog enable and disable codes, then a bad one.
   task automatic t_wdog_ctrl;
      bus(1'b1, rsc_pkg::OFS_WDOG_CTRL, 32'hA8);
      check(wdog_enabled, 1'b0);
      bus(1'b1, rsc_pkg::OFS_WDOG_CTRL, 32'h53);
      check(wdog_enabled, 1'b1);
      t_soft(rsc_pkg::OFS_WDOG_CTRL, 32'h1B, 32'h1);
   endtask : t_wdog_ctrl

   // -------------------------------------------------------------------
   // Main sequence and hang guard
   // -------------------------------------------------------------------
   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         n_errors++;
         finish_test();
      end
   end

   // Runs the scenarios in turn.
   initial begin
      t_por();
      t_levels();
      t_idle();
      t_por();
      t_wdog_run();
      t_pin();
      t_supply();
      t_soft(rsc_pkg::OFS_TRIP_SELECT, 32'h12, 32'h2);
      t_soft(rsc_pkg::OFS_SELFPROG, 32'h55, 32'h0);
      t_wdog_ctrl();
      finish_test();
   end
endmodule : reset_source_controller_test
